// ### hdl/ssp_top.v
// Synchronous slave serial port: register file, transmit holding buffer and
// shifter, receive shifter and buffer, wake requests.
// Assumes an external master toggles the shift clock pin far slower than CLK
// and a core that drives the plain register port from CLK.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.vh"

module ssp_top (
  input  wire       CLK,
  input  wire       SRST,
  input  wire [2:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       SHIFT_CLOCK_PIN_I,
  input  wire       SHIFT_DATA_PIN_I,
  output reg        SHIFT_DATA_PIN_O,
  output reg        SHIFT_DATA_PIN_OE,
  output reg        TX_IRQ,
  output reg        RX_IRQ
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // The shift clock pin is an input only; the block never drives it.
  reg        ck_meta_q;
  reg        ck_sync_q;
  reg        ck_prev_q;
  reg        dt_meta_q;
  reg        dt_sync_q;
  wire       ck_fall;

  always @(posedge CLK) begin
    if (SRST) begin
      ck_meta_q <= 1'b0;
      ck_sync_q <= 1'b0;
      ck_prev_q <= 1'b0;
      dt_meta_q <= 1'b0;
      dt_sync_q <= 1'b0;
    end else begin
      ck_meta_q <= SHIFT_CLOCK_PIN_I; // R19
      ck_sync_q <= ck_meta_q;
      ck_prev_q <= ck_sync_q;
      dt_meta_q <= SHIFT_DATA_PIN_I;
      dt_sync_q <= dt_meta_q;
    end
  end

  assign ck_fall = ck_prev_q & ~ck_sync_q;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  reg        rx_irq_en_q;
  reg        tx_irq_en_q;
  reg        rx_irq_priority_q;
  reg        tx_irq_priority_q;
  reg        port_en_q;
  reg        rx_nine_bit_sel_q;
  reg        single_rx_en_q;
  reg        cont_rx_en_q;
  reg        addr_detect_en_q;
  reg        clk_source_sel_q;
  reg        tx_nine_bit_sel_q;
  reg        tx_en_a_q;
  reg        sync_sel_q;
  reg        high_rate_sel_q;
  reg        tx_ninth_bit_q;
  reg  [7:0] bit_rate_divisor_q;

  wire       wr_en;
  wire       wr_pri;
  wire       wr_rxs;
  wire       wr_hold;
  wire       wr_txs;
  wire       wr_div;
  wire       rd_buf;

  assign wr_en    = WR && (ADDR == `SSP_A_ENABLES);
  assign wr_pri   = WR && (ADDR == `SSP_A_PRIORITY);
  assign wr_rxs   = WR && (ADDR == `SSP_A_RXSTAT);
  assign wr_hold  = WR && (ADDR == `SSP_A_TXHOLD);
  assign wr_txs   = WR && (ADDR == `SSP_A_TXSTAT);
  assign wr_div   = WR && (ADDR == `SSP_A_DIVISOR);
  assign rd_buf   = RD && (ADDR == `SSP_A_RXBUF);

  always @(posedge CLK) begin
    if (SRST) begin
      rx_irq_en_q        <= `SSP_RST_BIT;
      tx_irq_en_q        <= `SSP_RST_BIT;
      rx_irq_priority_q  <= `SSP_RST_BIT;
      tx_irq_priority_q  <= `SSP_RST_BIT;
      port_en_q          <= `SSP_RST_BIT;
      rx_nine_bit_sel_q  <= `SSP_RST_BIT;
      single_rx_en_q     <= `SSP_RST_BIT;
      cont_rx_en_q       <= `SSP_RST_BIT;
      addr_detect_en_q   <= `SSP_RST_BIT;
      clk_source_sel_q   <= `SSP_RST_BIT;
      tx_nine_bit_sel_q  <= `SSP_RST_BIT;
      tx_en_a_q          <= `SSP_RST_BIT;
      sync_sel_q         <= `SSP_RST_BIT;
      high_rate_sel_q    <= `SSP_RST_BIT;
      tx_ninth_bit_q     <= `SSP_RST_BIT;
      bit_rate_divisor_q <= `SSP_RST_BYTE;
    end else begin
      if (wr_en) begin
        rx_irq_en_q <= WDATA[`SSP_B_RXIRQ];
        tx_irq_en_q <= WDATA[`SSP_B_TXIRQ];
      end
      if (wr_pri) begin
        rx_irq_priority_q <= WDATA[`SSP_B_RXIRQ];
        tx_irq_priority_q <= WDATA[`SSP_B_TXIRQ];
      end
      if (wr_rxs) begin
        port_en_q         <= WDATA[`SSP_B_PORTEN];
        rx_nine_bit_sel_q <= WDATA[`SSP_B_RXNINE];
        single_rx_en_q    <= WDATA[`SSP_B_SRX];
        cont_rx_en_q      <= WDATA[`SSP_B_CRX];
        addr_detect_en_q  <= WDATA[`SSP_B_ADDR];
      end
      if (wr_txs) begin
        clk_source_sel_q  <= WDATA[`SSP_B_CLKSRC];
        tx_nine_bit_sel_q <= WDATA[`SSP_B_TXNINE];
        tx_en_a_q         <= WDATA[`SSP_B_TXON];
        sync_sel_q        <= WDATA[`SSP_B_SYNC];
        high_rate_sel_q   <= WDATA[`SSP_B_HIRATE];
        tx_ninth_bit_q    <= WDATA[`SSP_B_TXBIT8];
      end
      if (wr_div) begin
        bit_rate_divisor_q <= WDATA;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------------
  // Half duplex: continuous receive takes the line away from the transmitter.
  // The single-receive enable is stored and read back but steers nothing.
  wire       slave_on;
  wire       tx_mode;
  wire       rx_mode;
  reg        shift_busy_q;

  assign slave_on = port_en_q & sync_sel_q & ~clk_source_sel_q;
  assign tx_mode  = slave_on & tx_en_a_q & ~cont_rx_en_q;             // R1
  assign rx_mode  = slave_on & cont_rx_en_q & ~shift_busy_q;          // R11

  // --------------------------------------------------------------------------
  // Transmit holding buffer and shifter
  // --------------------------------------------------------------------------
  reg  [7:0] tx_holding_buf_q;
  reg        hold_ninth_q;
  reg        hold_full_q;
  reg        tx_empty_flag_q;
  reg  [8:0] tx_shift_reg_q;
  reg  [3:0] tx_cnt_q;
  reg  [3:0] tx_len_q;
  wire       tx_load;

  // A load is held off for the cycle of a holding-buffer write so that the
  // flag never sees a set and a clear together.
  assign tx_load = hold_full_q & ~shift_busy_q & tx_mode & ~wr_hold;  // R2

  always @(posedge CLK) begin
    if (SRST) begin
      tx_holding_buf_q <= `SSP_RST_BYTE;
      hold_ninth_q     <= `SSP_RST_BIT;
      hold_full_q      <= `SSP_RST_BIT;
      tx_empty_flag_q  <= `SSP_RST_EMPTY;
    end else if (wr_hold) begin
      tx_holding_buf_q <= WDATA;
      hold_ninth_q     <= tx_ninth_bit_q;
      hold_full_q      <= 1'b1;                                       // R3
      tx_empty_flag_q  <= 1'b0;                                       // R21
    end else if (tx_load) begin
      hold_full_q      <= 1'b0;
      tx_empty_flag_q  <= 1'b1;                                       // R5
    end else begin
      tx_empty_flag_q  <= tx_empty_flag_q & ~hold_full_q;             // R4
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      tx_shift_reg_q <= 9'h000;
      shift_busy_q   <= 1'b0;
      tx_cnt_q       <= `SSP_CNT_ZERO;
      tx_len_q       <= `SSP_LEN8;
    end else if (tx_load) begin
      tx_shift_reg_q <= {hold_ninth_q, tx_holding_buf_q};
      shift_busy_q   <= 1'b1;
      tx_cnt_q       <= `SSP_CNT_ZERO;
      tx_len_q       <= tx_nine_bit_sel_q ? `SSP_LEN9 : `SSP_LEN8;    // R23
    end else if (shift_busy_q && !tx_mode) begin
      shift_busy_q   <= 1'b0;
    end else if (shift_busy_q && ck_fall) begin
      // The master has sampled the bit at this falling edge; move on.
      tx_shift_reg_q <= {1'b0, tx_shift_reg_q[8:1]};                  // R23
      tx_cnt_q       <= tx_cnt_q + `SSP_CNT_ONE;
      if (tx_cnt_q == tx_len_q - `SSP_CNT_ONE) begin
        shift_busy_q <= 1'b0;                                         // R5
      end
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      SHIFT_DATA_PIN_O  <= 1'b0;
      SHIFT_DATA_PIN_OE <= 1'b0;
    end else begin
      SHIFT_DATA_PIN_O  <= tx_shift_reg_q[0];
      SHIFT_DATA_PIN_OE <= shift_busy_q & tx_mode;
    end
  end

  // --------------------------------------------------------------------------
  // Receive shifter and buffer
  // --------------------------------------------------------------------------
  // Reception is clocked by CLK and steps on synchronised falls of the pin clock,
  // so it stops whenever CLK stops; the block has no power-state input.
  reg  [8:0] rx_shift_reg_q;
  reg  [3:0] rx_cnt_q;
  reg  [7:0] rx_buf_q;
  reg        rx_ninth_bit_q;
  reg        rx_done_flag_q;
  reg        overrun_err_q;
  reg        framing_err_q;
  wire [8:0] rx_next;
  wire [3:0] rx_len;
  wire       rx_word;
  wire       rx_overrun;

  assign rx_next    = {dt_sync_q, rx_shift_reg_q[8:1]};
  assign rx_len     = rx_nine_bit_sel_q ? `SSP_LEN9 : `SSP_LEN8;
  assign rx_word    = rx_mode & ck_fall & (rx_cnt_q == rx_len - `SSP_CNT_ONE);
  assign rx_overrun = rx_word & rx_done_flag_q & ~rd_buf;

  always @(posedge CLK) begin
    if (SRST) begin
      rx_shift_reg_q <= 9'h000;
      rx_cnt_q       <= `SSP_CNT_ZERO;
    end else if (!rx_mode) begin
      rx_cnt_q       <= `SSP_CNT_ZERO;
    end else if (ck_fall) begin // R12
      rx_shift_reg_q <= rx_next;                                      // R20
      rx_cnt_q       <= rx_word ? `SSP_CNT_ZERO : rx_cnt_q + `SSP_CNT_ONE; // R23
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      rx_buf_q       <= `SSP_RST_BYTE;
      rx_ninth_bit_q <= `SSP_RST_BIT;
      rx_done_flag_q <= `SSP_RST_BIT;
      overrun_err_q  <= `SSP_RST_BIT;
      framing_err_q  <= `SSP_RST_BIT;
    end else begin
      if (rx_word && !rx_overrun) begin
        rx_buf_q       <= rx_nine_bit_sel_q ? rx_next[7:0] : rx_next[8:1]; // R13
        rx_ninth_bit_q <= rx_nine_bit_sel_q & rx_next[8];
      end
      // A completion in the cycle of the buffer read keeps the flag set.
      rx_done_flag_q <= (rx_word & ~rx_overrun) | (rx_done_flag_q & ~rd_buf); // R14
      if (!cont_rx_en_q) begin
        overrun_err_q <= 1'b0;                                        // R17
        framing_err_q <= 1'b0;                                        // R17
      end else if (rx_overrun) begin
        overrun_err_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Wake requests
  // --------------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      TX_IRQ <= 1'b0;
      RX_IRQ <= 1'b0;
    end else begin
      TX_IRQ <= tx_empty_flag_q & tx_irq_en_q;                        // R6
      RX_IRQ <= rx_done_flag_q & rx_irq_en_q;                         // R13
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  reg  [7:0] rd_mux;

  always @* begin
    rd_mux = `SSP_RST_BYTE;
    case (ADDR)
      `SSP_A_FLAGS: begin
        rd_mux[`SSP_B_RXIRQ] = rx_done_flag_q;
        rd_mux[`SSP_B_TXIRQ] = tx_empty_flag_q;
      end
      `SSP_A_ENABLES: begin
        rd_mux[`SSP_B_RXIRQ] = rx_irq_en_q;
        rd_mux[`SSP_B_TXIRQ] = tx_irq_en_q;
      end
      `SSP_A_PRIORITY: begin
        rd_mux[`SSP_B_RXIRQ] = rx_irq_priority_q;
        rd_mux[`SSP_B_TXIRQ] = tx_irq_priority_q;
      end
      `SSP_A_RXSTAT: begin
        rd_mux[`SSP_B_PORTEN] = port_en_q;
        rd_mux[`SSP_B_RXNINE]  = rx_nine_bit_sel_q;
        rd_mux[`SSP_B_SRX]     = single_rx_en_q;
        rd_mux[`SSP_B_CRX]     = cont_rx_en_q;
        rd_mux[`SSP_B_ADDR]    = addr_detect_en_q;
        rd_mux[`SSP_B_FRAMERR] = framing_err_q;
        rd_mux[`SSP_B_OVRERR]  = overrun_err_q;
        rd_mux[`SSP_B_RXBIT8]  = rx_ninth_bit_q;
      end
      `SSP_A_TXHOLD: begin
        rd_mux = tx_holding_buf_q;
      end
      `SSP_A_TXSTAT: begin
        rd_mux[`SSP_B_CLKSRC]  = clk_source_sel_q;
        rd_mux[`SSP_B_TXNINE]  = tx_nine_bit_sel_q;
        rd_mux[`SSP_B_TXON]    = tx_en_a_q;
        rd_mux[`SSP_B_SYNC]    = sync_sel_q;
        rd_mux[`SSP_B_HIRATE]  = high_rate_sel_q;
        rd_mux[`SSP_B_SHEMPTY] = ~shift_busy_q;                       // R22
        rd_mux[`SSP_B_TXBIT8]  = tx_ninth_bit_q;
      end
      `SSP_A_DIVISOR: begin
        rd_mux = bit_rate_divisor_q;
      end
      `SSP_A_RXBUF: begin
        rd_mux = rx_buf_q;
      end
      default: begin
        rd_mux = `SSP_RST_BYTE;
      end
    endcase
  end

  // Writes to the flag register have no effect; both flags are hardware-owned.
  always @(posedge CLK) begin
    if (SRST) begin
      RDATA <= `SSP_RST_BYTE;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= `SSP_RST_BYTE;
    end
  end

endmodule
`default_nettype wire

// ### inc/ssp_defs.vh
// Constants of the synchronous slave serial port: register indices, bit
// positions, reset values and word lengths.
// Assumes it is included by its bare name from the design file.
//
// Operation
// [R1] Slave transmit works like master transmit, apart from low-power behaviour.
// [R2] With two words written, the first moves to the shifter at once.
// [R3] The second word waits in the holding buffer while the first shifts.
// [R4] Buffer-empty flag stays clear while the holding buffer is occupied.
// [R5] After the first word, the second is moved and buffer-empty sets.
// [R6] Buffer-empty with transmit enable raises the transmit wake request.
// [R7] Software selects clocked mode, enables port, clears clock-source select.
// [R8] Software clears both receive enables before slave transmission.
// [R9] Software sets nine-bit transmit and loads the ninth bit first.
// [R10] Software sets transmit enable then writes a word to start.
// [R11] Single-receive enable is ignored; only continuous receive controls reception.
// [R12] Words clocked in during low-power states are still accepted; here reception stops whenever CLK stops.
// [R13] A complete word moves to the receive buffer and may wake core.
// [R14] Completion sets receive-done; request only when receive enable set.
// [R15] Software selects nine-bit receive before enabling continuous receive.
// [R16] Software reads status before reading the received data byte.
// [R17] Clearing continuous receive clears the error state.
// [R18] Software sets global and peripheral interrupt enables when used.
// [R19] The external master supplies the shift clock; device never drives it.
// [R20] Received data is sampled at the falling shift clock edge.
// [R21] Buffer-empty is cleared only by writing the holding buffer.
// [R22] Read-only shifter-empty bit shows the shifter empty, no interrupt.
// [R23] One bit per clock period, words of 8 or 9 bits.
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define SSP_A_FLAGS      3'h0
`define SSP_A_ENABLES    3'h1
`define SSP_A_PRIORITY   3'h2
`define SSP_A_RXSTAT     3'h3
`define SSP_A_TXHOLD     3'h4
`define SSP_A_TXSTAT     3'h5
`define SSP_A_DIVISOR    3'h6
`define SSP_A_RXBUF      3'h7

// ----------------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------------
`define SSP_B_RXIRQ      5
`define SSP_B_TXIRQ      4
`define SSP_B_PORTEN     7
`define SSP_B_RXNINE     6
`define SSP_B_SRX        5
`define SSP_B_CRX        4
`define SSP_B_ADDR       3
`define SSP_B_FRAMERR    2
`define SSP_B_OVRERR     1
`define SSP_B_RXBIT8     0
`define SSP_B_CLKSRC     7
`define SSP_B_TXNINE     6
`define SSP_B_TXON       5
`define SSP_B_SYNC       4
`define SSP_B_HIRATE     2
`define SSP_B_SHEMPTY    1
`define SSP_B_TXBIT8     0

// ----------------------------------------------------------------------------
// Reset values and word lengths
// ----------------------------------------------------------------------------
`define SSP_RST_BYTE     8'h00
`define SSP_RST_BIT      1'b0
`define SSP_RST_EMPTY    1'b1
`define SSP_LEN8         4'h8
`define SSP_LEN9         4'h9
`define SSP_CNT_ZERO     4'h0
`define SSP_CNT_ONE      4'h1

`endif

// ### test/ssp_top_sva.sv
// Checker of the slave serial port, watching only the top module's ports.
// Assumes the register indices and bit positions of ssp_defs.vh.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.vh"

module ssp_top_sva (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       SHIFT_CLOCK_PIN_I,
  input wire logic       SHIFT_DATA_PIN_I,
  input wire logic       SHIFT_DATA_PIN_O,
  input wire logic       SHIFT_DATA_PIN_OE,
  input wire logic       TX_IRQ,
  input wire logic       RX_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // --------------------------------------------------------------------------
  // Shadow of the control registers and shift clock edge tracking
  // --------------------------------------------------------------------------
  logic       pin_q;
  logic [3:0] age_q;
  logic [3:0] nfall_q;
  logic [7:0] enb_q;
  logic [7:0] rxs_q;
  logic [7:0] txs_q;
  wire        fall   = pin_q & ~SHIFT_CLOCK_PIN_I;
  wire        cfg_ok = rxs_q[`SSP_B_PORTEN] & ~rxs_q[`SSP_B_CRX] & txs_q[`SSP_B_SYNC]
                     & txs_q[`SSP_B_TXON] & ~txs_q[`SSP_B_CLKSRC];

  always @(posedge CLK) begin
    pin_q <= SHIFT_CLOCK_PIN_I;
    if (SRST) begin
      age_q   <= 4'h0;
      nfall_q <= 4'h0;
      enb_q   <= 8'h00;
      rxs_q   <= 8'h00;
      txs_q   <= 8'h00;
    end else begin
      age_q   <= fall ? 4'h0 : ((age_q == 4'hF) ? age_q : age_q + 4'h1);
      nfall_q <= SHIFT_DATA_PIN_OE ? nfall_q + {3'h0, fall} : 4'h0;
      if (WR && ADDR == `SSP_A_ENABLES) enb_q <= WDATA;
      if (WR && ADDR == `SSP_A_RXSTAT) rxs_q <= WDATA;
      if (WR && ADDR == `SSP_A_TXSTAT) txs_q <= WDATA;
    end
  end

  sequence s_rxbuf_read;
    RD && ADDR == `SSP_A_RXBUF && RX_IRQ;
  endsequence
  sequence s_irq_drop;
    ##[1:3] !RX_IRQ;
  endsequence

  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read cycle");
  a_flags_rsvd: assert property (RD && ADDR == `SSP_A_FLAGS |=> (RDATA & 8'hCF) == 8'h00)
    else $error("reserved flag bits read nonzero");
  a_txstat_readback: assert property (RD && ADDR == `SSP_A_TXSTAT |=>
    RDATA[7:4] == txs_q[7:4] && !RDATA[3]) else $error("transmit control readback wrong");
  a_tx_irq_mask: assert property (TX_IRQ |-> $past(enb_q[`SSP_B_TXIRQ]))
    else $error("transmit request while disabled");
  a_rx_irq_mask: assert property (RX_IRQ |-> $past(enb_q[`SSP_B_RXIRQ]))
    else $error("receive request while disabled");
  a_oe_config: assert property (SHIFT_DATA_PIN_OE |-> $past(cfg_ok) || $past(cfg_ok, 2))
    else $error("data line driven outside slave transmit");
  a_bit_timing: assert property ($changed(SHIFT_DATA_PIN_O) && SHIFT_DATA_PIN_OE
    && $past(SHIFT_DATA_PIN_OE) |-> age_q <= 4'h5) else $error("data bit moved off clock edge");
  a_word_len: assert property (SHIFT_DATA_PIN_OE |->
    nfall_q <= (txs_q[`SSP_B_TXNINE] ? 4'h9 : 4'h8)) else $error("word longer than framed");
  a_read_clears: assert property (s_rxbuf_read |-> s_irq_drop)
    else $error("receive request stays after buffer read");
endmodule

bind ssp_top ssp_top_sva u_sva (
  .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SHIFT_CLOCK_PIN_I(SHIFT_CLOCK_PIN_I), .SHIFT_DATA_PIN_I(SHIFT_DATA_PIN_I),
  .SHIFT_DATA_PIN_O(SHIFT_DATA_PIN_O), .SHIFT_DATA_PIN_OE(SHIFT_DATA_PIN_OE),
  .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ));
`default_nettype wire

// ### test/ssp_master_model.sv
// External synchronous master: makes the shift clock and moves one word.
// Assumes the bench resolves the shared data line from all enables.
`timescale 1ns/1ns
`default_nettype none

module ssp_master_model (
  output logic      sck,
  output logic      d_o,
  output logic      oe_o,
  input  wire logic dt
);
  initial begin
    sck  = 1'b1;
    d_o  = 1'b0;
    oe_o = 1'b0;
  end

  // The clock idles high between frames; the slave acts on each falling edge.
  task automatic shift(input int n, input logic [8:0] tx, input int half, input logic drv,
                       output logic [8:0] rx);
    rx = 9'h000;
    #7;
    oe_o = drv;
    for (int k = 0; k < n; k++) begin
      d_o = tx[k];
      #(half);
      rx[k] = dt;
      sck = 1'b0;
      #(half);
      sck = 1'b1;
    end
    oe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/sync_slave_serial_port_tb_top.sv
// Testbench of the slave serial port: register tasks and link scenarios.
// Assumes the design, its checker and the master model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.vh"

module sync_slave_serial_port_tb_top;
  logic       CLK     = 1'b0;
  logic       SRST    = 1'b1;
  logic [2:0] ADDR    = 3'h0;
  logic [7:0] WDATA   = 8'h00;
  logic       WR      = 1'b0;
  logic       RD      = 1'b0;
  logic       dt_last = 1'b0;
  wire  [7:0] RDATA;
  wire        sck, m_d, m_oe, dt_o, dt_oe, TX_IRQ, RX_IRQ, dt;
  logic [7:0] v;
  logic [8:0] r;
  int         num_errors = 0;
  int         tests_run  = 0;
  int         cyc        = 0;
  int         i;

  always #20 CLK = ~CLK;
  // A released data line shows the inverse of its last level.
  assign dt = dt_oe ? dt_o : (m_oe ? m_d : ~dt_last);
  always @(posedge CLK) begin
    if (dt_oe || m_oe) begin
      dt_last <= dt;
    end
  end

  ssp_top dut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SHIFT_CLOCK_PIN_I(sck), .SHIFT_DATA_PIN_I(dt), .SHIFT_DATA_PIN_O(dt_o),
    .SHIFT_DATA_PIN_OE(dt_oe), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ));
  ssp_master_model m (.sck(sck), .d_o(m_d), .oe_o(m_oe), .dt(dt));

  // --------------------------------------------------------------------------
  // Bus tasks and comparison
  // --------------------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    rd(a, v);
    check(v, e);
  endtask
  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    rc(`SSP_A_TXSTAT, 8'h02);
    rc(`SSP_A_FLAGS, 8'h10);
    wr(`SSP_A_FLAGS, 8'h00);
    rc(`SSP_A_FLAGS, 8'h10);
    wr(`SSP_A_DIVISOR, 8'h5C);
    rc(`SSP_A_DIVISOR, 8'h5C);
    wr(`SSP_A_PRIORITY, 8'h30);
    rc(`SSP_A_PRIORITY, 8'h30);
    rc(`SSP_A_RXBUF, 8'h00);
    $display("Test registers done");
    wr(`SSP_A_RXSTAT, 8'h80);
    wr(`SSP_A_ENABLES, 8'h10);
    wr(`SSP_A_TXSTAT, 8'h30);
    wr(`SSP_A_TXHOLD, 8'hA5);
    wr(`SSP_A_TXHOLD, 8'h3C);
    rc(`SSP_A_FLAGS, 8'h00);
    rc(`SSP_A_TXSTAT, 8'h30);
    check(TX_IRQ, 1'b0);
    m.shift(8, 9'h000, 160, 1'b0, r);
    check(r, 9'h0A5);
    repeat (8) @(posedge CLK);
    rc(`SSP_A_FLAGS, 8'h10);
    check(TX_IRQ, 1'b1);
    m.shift(8, 9'h000, 400, 1'b0, r);
    check(r, 9'h03C);
    repeat (8) @(posedge CLK);
    rc(`SSP_A_TXSTAT, 8'h32);
    wr(`SSP_A_TXSTAT, 8'h71);
    wr(`SSP_A_TXHOLD, 8'h5A);
    m.shift(9, 9'h000, 160, 1'b0, r);
    check(r, 9'h15A);
    repeat (8) @(posedge CLK);
    $display("Test transmit done");
    wr(`SSP_A_TXSTAT, 8'h10);
    wr(`SSP_A_ENABLES, 8'h20);
    wr(`SSP_A_RXSTAT, 8'hA0);
    m.shift(8, 9'h077, 160, 1'b1, r);
    repeat (8) @(posedge CLK);
    rc(`SSP_A_FLAGS, 8'h10);
    check(RX_IRQ, 1'b0);
    wr(`SSP_A_RXSTAT, 8'h90);
    m.shift(8, 9'h06B, 160, 1'b1, r);
    for (i = 0; i < 20 && RX_IRQ !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    check(RX_IRQ, 1'b1);
    rc(`SSP_A_FLAGS, 8'h30);
    rd(`SSP_A_RXSTAT, v);
    check(v & 8'hFE, 8'h90);
    rc(`SSP_A_RXBUF, 8'h6B);
    wr(`SSP_A_RXSTAT, 8'hC0);
    wr(`SSP_A_RXSTAT, 8'hD0);
    m.shift(9, 9'h1C4, 160, 1'b1, r);
    m.shift(9, 9'h0E1, 400, 1'b1, r);
    repeat (8) @(posedge CLK);
    rc(`SSP_A_RXSTAT, 8'hD3);
    rc(`SSP_A_RXBUF, 8'hC4);
    wr(`SSP_A_RXSTAT, 8'hC0);
    rd(`SSP_A_RXSTAT, v);
    check(v & 8'hFE, 8'hC0);
    $display("Test receive done");
    summarize();
  end
endmodule
`default_nettype wire
